//--- bench/pct_core_seq_monitor.sv
// Purpose: Port checker for the cycle-timing sequencer
// Assumes: One clock, nrst asynchronous active low
// Notes: Bound onto every sequencer instance
`timescale 1ns/1ns
`default_nettype none
module pct_core_seq_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] xdm_addr,
  input wire logic flash_wr_en,
  input wire logic [15:0] cm_addr,
  input wire logic [15:0] code_addr,
  input wire logic code_rd,
  input wire logic cm_rd,
  input wire logic instr_done,
  input wire logic instr_taken,
  input wire logic [7:0] instr_op,
  input wire logic xdm_req,
  input wire logic xdm_we,
  input wire logic [15:0] xdm_addr_out,
  input wire logic [1:0] xdm_target,
  input wire logic halted
);
  logic [3:0] gap;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Clocks since the last completion or halted clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap <= 4'h0;
    end else if (instr_done || halted) begin
      gap <= 4'h0;
    end else if (gap != 4'hf) begin
      gap <= gap + 4'h1;
    end
  end
  AST_MAX_CLOCKS: assert property (gap <= 4'h8)
    else $error("instruction longer than eight clocks");
  AST_TAKEN_DONE: assert property (instr_taken |-> instr_done)
    else $error("taken flag without completion");
  AST_XDM_GAP: assert property (xdm_req |=> !xdm_req ##1 !xdm_req)
    else $error("external moves too close");
  AST_XDM_DONE: assert property (xdm_req |-> ##2 (instr_done
    && instr_op[7:5] == 3'h7 && instr_op[3:2] == 2'h0))
    else $error("external move did not end two clocks later");
  AST_XDM_ADDR: assert property (xdm_req |->
    xdm_addr_out == $past(xdm_addr))
    else $error("external address not taken from clock one");
  AST_XDM_FLASH: assert property (xdm_req && xdm_we
    && $past(flash_wr_en) |-> xdm_target == 2'h2)
    else $error("flash write not steered to flash");
  AST_XDM_LOCAL: assert property (xdm_req && !xdm_we
    && xdm_addr_out < 16'h1000 |-> xdm_target == 2'h0)
    else $error("low read not steered on chip");
  AST_CODE_MEMORY_MOVE_READ: assert property (cm_rd |->
    code_addr == $past(cm_addr) ##2 instr_done)
    else $error("code move address or timing wrong");
  AST_HALT_IDLE: assert property (halted |->
    !code_rd && !cm_rd && !xdm_req)
    else $error("activity while halted");
  // Main scenarios
  cover property (xdm_req && xdm_target == 2'h2);
  cover property (instr_taken);
  cover property ($rose(halted));
endmodule
bind pct_core_seq pct_core_seq_monitor i_mon (.clk(clk), .nrst(nrst),
  .xdm_addr(xdm_addr), .flash_wr_en(flash_wr_en), .cm_addr(cm_addr),
  .code_addr(code_addr), .code_rd(code_rd), .cm_rd(cm_rd),
  .instr_done(instr_done), .instr_taken(instr_taken),
  .instr_op(instr_op), .xdm_req(xdm_req), .xdm_we(xdm_we),
  .xdm_addr_out(xdm_addr_out), .xdm_target(xdm_target),
  .halted(halted));
`default_nettype wire

//--- bench/pct_core_seq_tb.sv
// Purpose: Self-checking bench for the cycle-timing sequencer
// Assumes: Program memory model answers in the same clock
// Notes: Model walks the program with a timing table
`timescale 1ns/1ns
`default_nettype none
module pct_core_seq_tb;
  localparam int NEXP = 18;
  logic clk, nrst, cond_true, jump_valid, flash_wr_en, wr_en;
  logic dbg_halt_req, dbg_run_req, dbg_step_req, bp_en, wp_en;
  logic [15:0] jump_addr, xdm_addr, cm_addr, bp_addr, wp_addr, wr_addr;
  logic [15:0] code_addr, xdm_addr_out;
  logic [7:0] wr_data, code_data, instr_op;
  logic code_rd, cm_rd, instr_done, instr_taken, xdm_req, xdm_we, halted;
  logic [1:0] xdm_target;
  integer seed = 32'h2217;
  int n_fail = 0;
  int cmp_count = 0;
  int tick = 0;
  int i, n;
  int eop[$], ecy[$], etk[$];
  int prog[$] = '{8'h28, 8'h26, 8'h25, 8'h00, 8'h24, 8'h00, 8'h53, 8'h00,
    8'h00, 8'h52, 8'h00, 8'ha3, 8'h06, 8'h84, 8'hf0, 8'he0, 8'h93,
    8'h40, 8'h01, 8'ha5, 8'ha4};

  pct_prog_mem i_mem (.clk, .code_addr, .code_rd, .wr_en, .wr_addr,
    .wr_data, .code_data);
  pct_core_seq i_dut (.clk, .nrst, .code_data, .cond_true, .jump_valid,
    .jump_addr, .xdm_addr, .flash_wr_en, .cm_addr, .dbg_halt_req,
    .dbg_run_req, .dbg_step_req, .bp_en, .bp_addr, .wp_en, .wp_addr,
    .code_addr, .code_rd, .cm_rd, .instr_done, .instr_taken, .instr_op,
    .xdm_req, .xdm_we, .xdm_addr_out, .xdm_target, .halted);

  function automatic int at(int a);
    return (a < prog.size()) ? prog[a] : 0;
  endfunction
  // Length in upper nibble, clocks in lower
  function automatic int tim(int op);
    case (op)
      8'h26, 8'h06: return 8'h12;
      8'h25, 8'h24, 8'h52: return 8'h22;
      8'h53: return 8'h33;
      8'h84: return 8'h18;
      8'ha4: return 8'h14;
      8'hf0, 8'he0, 8'h93: return 8'h13;
      8'h40: return 8'h23;
      default: return 8'h11;
    endcase
  endfunction
  task automatic build(input bit tk);
    int pc, v, cy;
    pc = 0;
    eop.delete();
    ecy.delete();
    etk.delete();
    repeat (NEXP) begin
      v = tim(at(pc));
      cy = v % 16;
      eop.push_back(at(pc));
      etk.push_back(0);
      if (at(pc) == 8'h40) begin
        cy = tk ? cy : cy - 1;
        etk[$] = tk;
        pc = tk ? pc + int'(byte'(at(pc + 1))) : pc;
      end
      ecy.push_back(cy);
      pc = pc + v / 16;
    end
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic run_pass(input bit tk);
    int k, t, last, nx, nc, ex, ec;
    build(tk);
    k = 0;
    t = 0;
    last = 0;
    nx = 0;
    nc = 0;
    ex = 0;
    ec = 0;
    // Expected external and code moves in this pass
    foreach (eop[j]) begin
      ex += int'(eop[j] == 8'hf0 || eop[j] == 8'he0);
      ec += int'(eop[j] == 8'h93);
    end
    @(posedge clk);
    nrst <= 1'b0;
    cond_true <= tk;
    flash_wr_en <= tk;
    xdm_addr <= (16'($random(seed)) & 16'h0fff) | {3'h0, tk, 12'h000};
    cm_addr <= 16'($random(seed));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    while (k < NEXP) begin
      @(negedge clk);
      t++;
      if (xdm_req === 1'b1) begin
        nx++;
        cmp(xdm_we, eop[k] == 8'hf0);
        cmp(xdm_addr_out, xdm_addr);
        cmp(xdm_target, (eop[k] == 8'hf0 && tk) ? 2 : int'(tk));
      end
      if (cm_rd === 1'b1) begin
        nc++;
        cmp(code_addr, cm_addr);
      end
      if (instr_done === 1'b1) begin
        cmp(instr_op, eop[k]);
        cmp(instr_taken, etk[k]);
        if (k > 0) cmp(t - last, ecy[k]);
        last = t;
        k++;
      end
    end
    cmp(nx, ex);
    cmp(nc, ec);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    tick <= tick + 1;
    if (tick == 3000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    {nrst, cond_true, jump_valid, flash_wr_en, wr_en} = 5'h00;
    {dbg_halt_req, dbg_run_req, dbg_step_req, bp_en, wp_en} = 5'h00;
    {jump_addr, xdm_addr, cm_addr, wr_addr, wr_data} = 72'h0;
    bp_addr = 16'($random(seed));
    wp_addr = 16'($random(seed));
    for (i = 0; i < prog.size(); i++) begin
      @(posedge clk);
      wr_en <= 1'b1;
      wr_addr <= 16'(i);
      wr_data <= 8'(prog[i]);
    end
    @(posedge clk);
    wr_en <= 1'b0;
    run_pass(1'b0);
    run_pass(1'b1);
    // Halt, single step, resume
    @(posedge clk);
    dbg_halt_req <= 1'b1;
    for (i = 0; i < 20 && halted !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    dbg_halt_req <= 1'b0;
    repeat (3) @(negedge clk);
    cmp(code_rd, 1'b0);
    cmp(instr_done, 1'b0);
    @(posedge clk);
    dbg_step_req <= 1'b1;
    @(posedge clk);
    dbg_step_req <= 1'b0;
    n = 0;
    repeat (12) begin
      @(negedge clk);
      n = n + int'(instr_done === 1'b1);
    end
    cmp(n, 1);
    cmp(halted, 1'b1);
    @(posedge clk);
    dbg_run_req <= 1'b1;
    @(posedge clk);
    dbg_run_req <= 1'b0;
    repeat (4) @(negedge clk);
    cmp({halted, code_rd}, 2'h1);
    // Third reset: breakpoint on the divide, then a watched write
    @(posedge clk);
    nrst <= 1'b0;
    bp_en <= 1'b1;
    bp_addr <= 16'h000d;
    wp_en <= 1'b1;
    wp_addr <= xdm_addr;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (30) @(negedge clk);
    cmp(halted, 1'b1);
    cmp(instr_op, 8'h06);
    @(posedge clk);
    dbg_run_req <= 1'b1;
    @(posedge clk);
    dbg_run_req <= 1'b0;
    repeat (20) @(negedge clk);
    cmp(halted, 1'b1);
    cmp(instr_op, 8'hf0);
    close_out();
  end
endmodule
`default_nettype wire

//--- bench/pct_prog_mem.sv
// Purpose: Program memory model for the sequencer
// Assumes: Read answers in the same clock
// Notes: Idle bus shows the inverse of the last byte
`timescale 1ns/1ns
`default_nettype none
module pct_prog_mem (
  input wire logic clk,
  input wire logic [15:0] code_addr,
  input wire logic code_rd,
  input wire logic wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] code_data
);
  logic [7:0] mem [0:255] = '{default: 8'h00};
  logic [7:0] last = 8'h00;
  // Load port and last byte seen
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr[7:0]] <= wr_data;
    end
    if (code_rd) begin
      last <= code_data;
    end
  end
  // Asynchronous read
  always_comb begin
    code_data = code_rd ? mem[code_addr[7:0]] : ~last;
  end
endmodule
`default_nettype wire

//--- src/pct_core_seq.sv
// Purpose: Cycle-exact instruction sequencer with fetch, branch and debug
// Assumes: code_data holds the byte at code_addr in the same cycle;
//   the datapath supplies branch conditions, jump targets and addresses
// Notes: Result and flag computation stays in the datapath outside
`timescale 1ns/1ns
`default_nettype none
module pct_core_seq (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] code_data,
  input wire logic cond_true,
  input wire logic jump_valid,
  input wire logic [15:0] jump_addr,
  input wire logic [15:0] xdm_addr,
  input wire logic flash_wr_en,
  input wire logic [15:0] cm_addr,
  input wire logic dbg_halt_req,
  input wire logic dbg_run_req,
  input wire logic dbg_step_req,
  input wire logic bp_en,
  input wire logic [15:0] bp_addr,
  input wire logic wp_en,
  input wire logic [15:0] wp_addr,
  output logic [15:0] code_addr,
  output logic code_rd,
  output logic cm_rd,
  output logic instr_done,
  output logic instr_taken,
  output logic [7:0] instr_op,
  output logic xdm_req,
  output logic xdm_we,
  output logic [15:0] xdm_addr_out,
  output logic [1:0] xdm_target,
  output logic halted
);

  typedef struct packed {
    pct_pkg::pct_state_t st;
    logic [3:0] cnt;
    logic [7:0] op;
    logic [7:0] rel;
    logic [15:0] pc;
    logic [15:0] code_addr;
    logic code_rd;
    logic cm_rd;
    logic done;
    logic taken;
    logic [7:0] done_op;
    logic xdm_req;
    logic xdm_we;
    logic [15:0] xdm_addr;
    pct_pkg::pct_xtgt_t xdm_tgt;
    logic step;
    logic hold_pend;
    logic skip_bp;
  } pct_seq_t;

  pct_seq_t s;
  pct_seq_t n;
  pct_dec_if dec ();
  logic first;
  logic fetch;
  logic last_byte;
  logic last;
  logic bp_hit;
  logic [15:0] seq_pc;
  logic [7:0] rel_now;
  logic [15:0] target;

  pct_decoder u_dec (
    .d(dec)
  );

  // Opcode shown to the decoder: live byte in the first clock
  assign first = (s.st == pct_pkg::PCT_RUN) && (s.cnt == pct_pkg::CYC_FIRST);
  assign dec.op = first ? code_data : s.op;

  assign fetch = (s.st == pct_pkg::PCT_RUN) && (s.cnt <= {2'h0, dec.len});
  assign last_byte = fetch && (s.cnt == {2'h0, dec.len});
  assign seq_pc = fetch ? s.pc + 16'h0001 : s.pc;
  assign rel_now = last_byte ? code_data : s.rel;
  assign target = seq_pc + {{8{rel_now[7]}}, rel_now};

  assign last = (s.cnt == dec.cyc) ||
    (dec.cond && !cond_true && (s.cnt == dec.cyc - 4'h1));

  assign bp_hit = bp_en && (s.pc == bp_addr) && !s.skip_bp;

  // Next-state logic
  always_comb begin
    n = s;
    n.done = 1'b0;
    n.taken = 1'b0;
    n.cm_rd = 1'b0;
    n.xdm_req = 1'b0;
    n.xdm_we = 1'b0;
    case (s.st)
      pct_pkg::PCT_HALT: begin
        n.code_rd = 1'b0;
        if (dbg_run_req || dbg_step_req) begin
          n.st = pct_pkg::PCT_RUN;
          n.step = dbg_step_req;
          n.skip_bp = 1'b1;
          n.code_rd = 1'b1;
          n.cnt = pct_pkg::CYC_FIRST;
        end
      end
      pct_pkg::PCT_RUN: begin
        if (first && (dbg_halt_req || s.hold_pend || bp_hit)) begin
          n.st = pct_pkg::PCT_HALT;
          n.code_rd = 1'b0;
          n.hold_pend = 1'b0;
          n.step = 1'b0;
        end else begin
          if (fetch) begin
            n.pc = seq_pc;
          end
          if (first) begin
            n.op = code_data;
          end
          if (last_byte) begin
            n.rel = code_data;
          end
          if ((dec.xrd || dec.xwr) && s.cnt == pct_pkg::CYC_XDM_ISSUE) begin
            n.xdm_req = 1'b1;
            n.xdm_we = dec.xwr;
            n.xdm_addr = xdm_addr;
            if (dec.xwr && flash_wr_en) begin
              n.xdm_tgt = pct_pkg::PCT_XT_FLASH;
            end else if ({1'b0, xdm_addr} < pct_pkg::EXPANSION_RAM_SIZE) begin
              n.xdm_tgt = pct_pkg::PCT_XT_ONCHIP;
            end else begin
              n.xdm_tgt = pct_pkg::PCT_XT_OFFCHIP;
            end
            if (wp_en && xdm_addr == wp_addr) begin
              n.hold_pend = 1'b1;
            end
          end
          if (last) begin
            n.cnt = pct_pkg::CYC_FIRST;
            n.done = 1'b1;
            n.done_op = dec.op;
            n.skip_bp = 1'b0;
            if (s.step) begin
              n.hold_pend = 1'b1;
              n.step = 1'b0;
            end
            if (dec.rel && (!dec.cond || s.cnt == dec.cyc)) begin
              n.pc = target;
              n.taken = 1'b1;
            end else if (jump_valid) begin
              n.pc = jump_addr;
              n.taken = 1'b1;
            end
          end else begin
            n.cnt = s.cnt + 4'h1;
          end
          n.code_addr = n.pc;
          if (dec.cmov && s.cnt == pct_pkg::CYC_FIRST) begin
            n.cm_rd = 1'b1;
            n.code_addr = cm_addr;
          end
        end
      end
      default: begin
        n.st = pct_pkg::PCT_HALT;
        n.code_rd = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '{st: pct_pkg::PCT_RUN, cnt: pct_pkg::CYC_FIRST, op: 8'h00,
        rel: 8'h00, pc: pct_pkg::RESET_PC,
        code_addr: pct_pkg::RESET_PC, code_rd: 1'b1, cm_rd: 1'b0,
        done: 1'b0, taken: 1'b0, done_op: 8'h00, xdm_req: 1'b0,
        xdm_we: 1'b0, xdm_addr: 16'h0000,
        xdm_tgt: pct_pkg::PCT_XT_ONCHIP, step: 1'b0, hold_pend: 1'b0,
        skip_bp: 1'b0};
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  // debug state held privately here
  assign code_addr = s.code_addr;
  assign code_rd = s.code_rd;
  assign cm_rd = s.cm_rd;
  assign instr_done = s.done;
  assign instr_taken = s.taken;
  assign instr_op = s.done_op;
  assign xdm_req = s.xdm_req;
  assign xdm_we = s.xdm_we;
  assign xdm_addr_out = s.xdm_addr;
  assign xdm_target = s.xdm_tgt;
  assign halted = (s.st == pct_pkg::PCT_HALT);

endmodule
`default_nettype wire

//--- src/pct_dec_if.sv
// Purpose: Carrier between the sequencer and the opcode timing decoder
// Assumes: Purely combinational decode of one opcode byte
// Notes: Lengths in bytes, cycles in system clocks
`timescale 1ns/1ns
`default_nettype none
interface pct_dec_if;
  logic [7:0] op;
  logic [1:0] len;
  logic [3:0] cyc;
  logic cond;
  logic rel;
  logic xrd;
  logic xwr;
  logic cmov;

  modport dec (input op, output len, cyc, cond, rel, xrd, xwr, cmov);
  modport use_side (output op, input len, cyc, cond, rel, xrd, xwr, cmov);
endinterface
`default_nettype wire

//--- src/pct_decoder.sv
// Purpose: Opcode to byte length, clock count and class decode
// Assumes: All 256 codes decoded; the one spare code acts as a no-op
// Notes: Cycle count given is the taken path for conditional branches
`timescale 1ns/1ns
`default_nettype none
module pct_decoder (
  pct_dec_if.dec d
);

  // Slowest clock count, declared ahead of its use in the table
  localparam logic [3:0] CYC_MAX_L = pct_pkg::CYC_MAX;

  logic [3:0] hi;

  always_comb begin
    hi = d.op[7:4];
    d.len = 2'h1;
    d.cyc = 4'h1;
    d.cond = 1'b0;
    d.rel = 1'b0;
    d.xrd = 1'b0;
    d.xwr = 1'b0;
    d.cmov = 1'b0;
    if (d.op[3]) begin
      // Working register column
      // register operand single cycle except rows 7, 8, a, b and d
      case (hi)
        4'h7, 4'h8, 4'ha: begin
          d.len = 2'h2;
          d.cyc = 4'h2;
        end
        4'hb: begin
          d.len = 2'h3;
          d.cyc = 4'h4;
          d.cond = 1'b1;
          d.rel = 1'b1;
        end
        4'hd: begin
          d.len = 2'h2;
          d.cyc = 4'h3;
          d.cond = 1'b1;
          d.rel = 1'b1;
        end
        default: begin
          d.len = 2'h1;
          d.cyc = 4'h1;
        end
      endcase
    end else begin
      case (d.op[2:0])
        // Pointer indirect column
        3'h6, 3'h7: begin
          case (hi)
            4'h7, 4'h8, 4'ha: begin
              d.len = 2'h2;
              d.cyc = 4'h2;
            end
            4'hb: begin
              d.len = 2'h3;
              d.cyc = 4'h5;
              d.cond = 1'b1;
              d.rel = 1'b1;
            end
            default: begin
              d.len = 2'h1;
              d.cyc = 4'h2;
            end
          endcase
        end
        // Direct byte column
        3'h5: begin
          case (hi)
            4'h7, 4'h8: begin
              d.len = 2'h3;
              d.cyc = 4'h3;
            end
            4'ha: begin
              d.len = 2'h1;
              d.cyc = 4'h1;
            end
            4'hb, 4'hd: begin
              d.len = 2'h3;
              d.cyc = 4'h4;
              d.cond = 1'b1;
              d.rel = 1'b1;
            end
            default: begin
              d.len = 2'h2;
              d.cyc = 4'h2;
            end
          endcase
        end
        // Accumulator and immediate column
        3'h4: begin
          case (hi)
            4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf: begin
              d.len = 2'h1;
              d.cyc = 4'h1;
            end
            4'h8: begin
              d.len = 2'h1;
              d.cyc = CYC_MAX_L;
            end
            4'ha: begin
              d.len = 2'h1;
              d.cyc = 4'h4;
            end
            4'hb: begin
              d.len = 2'h3;
              d.cyc = 4'h4;
              d.cond = 1'b1;
              d.rel = 1'b1;
            end
            default: begin
              d.len = 2'h2;
              d.cyc = 4'h2;
            end
          endcase
        end
        3'h3: begin
          case (hi)
            4'h4, 4'h5, 4'h6: begin
              d.len = 2'h3;
              d.cyc = 4'h3;
            end
            4'h7, 4'h8, 4'h9: begin
              d.len = 2'h1;
              d.cyc = 4'h3;
              d.cmov = (hi != 4'h7);
            end
            4'he, 4'hf: begin
              d.len = 2'h1;
              d.cyc = 4'h3;
              d.xrd = (hi == 4'he);
              d.xwr = (hi == 4'hf);
            end
            default: begin
              d.len = 2'h1;
              d.cyc = 4'h1;
            end
          endcase
        end
        3'h2: begin
          case (hi)
            4'h0, 4'h1: begin
              d.len = 2'h3;
              d.cyc = 4'h4;
            end
            4'h2, 4'h3: begin
              d.len = 2'h1;
              d.cyc = 4'h5;
            end
            4'he, 4'hf: begin
              d.len = 2'h1;
              d.cyc = 4'h3;
              d.xrd = (hi == 4'he);
              d.xwr = (hi == 4'hf);
            end
            default: begin
              d.len = 2'h2;
              d.cyc = 4'h2;
            end
          endcase
        end
        3'h1: begin
          d.len = 2'h2;
          d.cyc = 4'h3;
        end
        default: begin
          case (hi)
            4'h0: begin
              d.len = 2'h1;
              d.cyc = 4'h1;
            end
            4'h1, 4'h2, 4'h3: begin
              d.len = 2'h3;
              d.cyc = 4'h4;
              d.cond = 1'b1;
              d.rel = 1'b1;
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
              d.len = 2'h2;
              d.cyc = 4'h3;
              d.cond = 1'b1;
              d.rel = 1'b1;
            end
            4'h8: begin
              d.len = 2'h2;
              d.cyc = 4'h3;
              d.rel = 1'b1;
            end
            4'h9: begin
              d.len = 2'h3;
              d.cyc = 4'h3;
            end
            4'he, 4'hf: begin
              d.len = 2'h1;
              d.cyc = 4'h3;
              d.xrd = (hi == 4'he);
              d.xwr = (hi == 4'hf);
            end
            default: begin
              d.len = 2'h2;
              d.cyc = 4'h2;
            end
          endcase
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- src/pct_pkg.sv
// Purpose: Shared constants and types for the core cycle-timing sequencer
// Assumes: One 125 MHz clock, asynchronous active-low reset
// Notes: Cycle figures are whole system clocks, never machine cycles
package pct_pkg;

  // Clock and reset
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [15:0] RESET_PC = 16'h0000;

  // Field widths
  localparam int CNT_W = 4;
  localparam int LEN_W = 2;

  // Timing bounds
  localparam logic [3:0] CYC_MAX = 4'h8;
  localparam logic [3:0] CYC_FIRST = 4'h1;
  localparam logic [3:0] CYC_XDM_ISSUE = 4'h1;

  // Size of the on-chip expansion RAM window in the external space
  localparam logic [16:0] EXPANSION_RAM_SIZE = 17'h01000;

  // Sequencer states
  typedef enum logic [0:0] {
    PCT_RUN,
    PCT_HALT
  } pct_state_t;

  // External-data move targets
  typedef enum logic [1:0] {
    PCT_XT_ONCHIP,
    PCT_XT_OFFCHIP,
    PCT_XT_FLASH
  } pct_xtgt_t;

endpackage
